// File: verilog/interrupt_priority_vector_unit.sv
// interrupt resolution and vector generation for maskable levels 22..52 and the nmi pair
// assumes request lines are level requests from logic on sys_clk_in; the core pulses
// accept_in for one cycle when it is at an instruction boundary able to take an event.
// Operation
// - simultaneous maskable requests: smallest programmed level wins, zero highest
// - watchdog overflow beats external nonmaskable pin when both present
// - restored pc goes to maskable, nonmaskable or debug save register by class
// - restored pc normally is the following instruction address
// - short loads and divides are abandoned, own address saved, re-executed
// - frame create/release restart only if stack pointer not yet updated
// - illegal opcode: faulting address equals restored pc minus four
// - levels 22..25 map to codes 01e0 to 0210
// - level 26 code 0220; clocked serial levels 27..30 codes 0230..0260
// - async serial 0/1 levels 31..34 codes 0270..02a0
// - conversion done level 35, code and handler 02b0
// - key return 36 code 0300; watch timer 37, 38 codes 0310, 0320
// - external pins 8..10 map to levels 39..41 codes 0330..0350
// - timer q1 overflow 42 code 0360; capture/compare 43..46 codes 0370..03a0
// - async serial 2 receive 47 code 03b0, transmit 48 code 03c0
// - each maskable source has its own mask; masked requests never granted
// - eight programmable levels; default order only breaks ties
`timescale 1ns/100ps
module interrupt_priority_vector_unit
    import intc_vec_pkg::*;
(
    // clock and reset
    input  wire logic                            sys_clk_in,
    input  wire logic                            srst_in,
    // request sources
    input  wire logic [NUM_SRC-1:0]              mask_req_in,
    input  wire logic [NUM_SRC-1:0]              mask_bit_in,
    input  wire logic [NUM_SRC*PRIO_W-1:0]       prio_level_in,
    input  wire logic                            ext_nmi_request_in,
    input  wire logic                            watchdog_overflow_request_in,
    input  wire logic                            illegal_opcode_exception_in,
    input  wire logic                            debug_trap_in,
    // core side
    input  wire logic                            accept_in,
    input  wire logic                            maskable_enable_in,
    input  wire intc_vec_pkg::pipe_state_t       pipe_in,
    output intc_vec_pkg::vector_t                vector_out,
    output logic [31:0]                          maskable_saved_pc_out,
    output logic [31:0]                          nonmaskable_saved_pc_out,
    output logic [31:0]                          debug_saved_pc_out
);
    import intc_vec_pkg::*;

    logic [NUM_SRC-1:0] live_req;
    logic [NUM_SRC-1:0] top_level_req;
    logic               pick_found;
    logic [4:0]         pick_index;
    logic               restart_now;
    logic [31:0]        resume_pc;
    vector_t            vec_ff, nxt_vec;
    logic [31:0]        mpc_ff, nxt_mpc, npc_ff, nxt_npc, dpc_ff, nxt_dpc;

    function automatic logic [31:0] handler_of(input logic [15:0] code);
        handler_of = {16'h0000, code};
    endfunction : handler_of

    assign live_req = mask_req_in & ~mask_bit_in;

    // live sources already at level 0: nothing outranks them, so the checks below can
    // name the winner without redoing the arbitration
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_top_level
        assign top_level_req[g] = live_req[g] && (prio_level_in[g*PRIO_W +: PRIO_W] == '0);
    end

    prio_pick i_prio_pick (
        .req_in    (live_req),
        .level_in  (prio_level_in),
        .found_out (pick_found),
        .index_out (pick_index)
    );

    // interrupted instruction restarts rather than completing
    assign restart_now = pipe_in.short_load || pipe_in.divide ||
                         (pipe_in.frame_op && !pipe_in.sp_updated);
    assign resume_pc = restart_now ? pipe_in.current_pc
                                   : pipe_in.following_instruction_address;

    always_comb begin
        nxt_vec  = '0;
        nxt_mpc  = mpc_ff;
        nxt_npc  = npc_ff;
        nxt_dpc  = dpc_ff;
        if (accept_in) begin
            if (watchdog_overflow_request_in || ext_nmi_request_in) begin
                // lower nmi is dropped here; its source must re-request if still wanted
                nxt_vec.valid       = 1'b1;
                nxt_vec.save_sel    = SAVE_NONMASKABLE;
                nxt_vec.code        = watchdog_overflow_request_in ? CODE_WDT
                                                                   : CODE_EXT_NMI;
                nxt_vec.restored_pc = resume_pc;
                nxt_vec.restart     = restart_now;
                nxt_npc             = resume_pc;
            end else if (illegal_opcode_exception_in || debug_trap_in) begin
                nxt_vec.valid       = 1'b1;
                nxt_vec.save_sel    = illegal_opcode_exception_in ? SAVE_NONMASKABLE
                                                                  : SAVE_DEBUG;
                nxt_vec.code        = CODE_ILLEGAL;
                nxt_vec.restored_pc = pipe_in.current_pc + ILLEGAL_OFFSET;
                if (illegal_opcode_exception_in)
                    nxt_npc = nxt_vec.restored_pc;
                else
                    nxt_dpc = nxt_vec.restored_pc;
            end else if (pick_found && maskable_enable_in) begin
                nxt_vec.valid       = 1'b1;
                nxt_vec.save_sel    = SAVE_MASKABLE;
                nxt_vec.code        = SRC_CODE[pick_index];
                nxt_vec.restored_pc = resume_pc;
                nxt_vec.restart     = restart_now;
                nxt_mpc             = resume_pc;
            end
            nxt_vec.handler = handler_of(nxt_vec.code);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            vec_ff <= '0;
            mpc_ff <= 32'h0000_0000;
            npc_ff <= 32'h0000_0000;
            dpc_ff <= 32'h0000_0000;
        end else begin
            vec_ff <= nxt_vec;
            mpc_ff <= nxt_mpc;
            npc_ff <= nxt_npc;
            dpc_ff <= nxt_dpc;
        end
    end

    assign vector_out               = vec_ff;
    assign maskable_saved_pc_out    = mpc_ff;
    assign nonmaskable_saved_pc_out = npc_ff;
    assign debug_saved_pc_out       = dpc_ff;

    sequence nmi_pair_s;
        accept_in && watchdog_overflow_request_in && ext_nmi_request_in;
    endsequence

    sequence nmi_pin_alone_s;
        accept_in && ext_nmi_request_in && !watchdog_overflow_request_in;
    endsequence

    // no nonmaskable request at an accept, so traps and maskable sources get their turn
    sequence nmi_quiet_s;
        accept_in && !watchdog_overflow_request_in && !ext_nmi_request_in;
    endsequence

    // maskable arbitration only counts once neither trap is raised and the core enables it
    sequence maskable_turn_s;
        nmi_quiet_s ##0 (maskable_enable_in && !illegal_opcode_exception_in && !debug_trap_in);
    endsequence

    chk_wdt_over_pin: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        nmi_pair_s |=> vector_out.code == CODE_WDT)
        else $error("watchdog did not win over nmi pin");
    chk_pin_nmi_alone: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        nmi_pin_alone_s |=> vector_out.code == CODE_EXT_NMI
        && vector_out.save_sel == SAVE_NONMASKABLE)
        else $error("nmi pin not taken as nonmaskable");
    chk_masked_never: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.save_sel == SAVE_MASKABLE |->
        !$past(mask_bit_in[pick_index]))
        else $error("masked source granted");
    chk_low_index_wins: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        maskable_turn_s ##0 (top_level_req[1:0] == 2'b11) |=> vector_out.code == 16'h01e0)
        else $error("default order tie broken wrongly");
    chk_level_beats: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        maskable_turn_s ##0 (top_level_req == 31'h4000_0000) |=> vector_out.code == 16'h0440)
        else $error("programmed level ignored");
    chk_disabled_refused: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        nmi_quiet_s ##0 (!maskable_enable_in && !illegal_opcode_exception_in && !debug_trap_in)
        |=> !vector_out.valid)
        else $error("maskable granted while disabled");
    chk_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !accept_in |=> !vector_out.valid)
        else $error("vector issued without accept");
    chk_save_maskable: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.save_sel == SAVE_MASKABLE |->
        maskable_saved_pc_out == vector_out.restored_pc)
        else $error("maskable save register mismatch");
    chk_save_nonmask: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.save_sel == SAVE_NONMASKABLE |->
        nonmaskable_saved_pc_out == vector_out.restored_pc)
        else $error("nonmaskable save register mismatch");
    chk_save_debug: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.save_sel == SAVE_DEBUG |->
        debug_saved_pc_out == vector_out.restored_pc)
        else $error("debug save register mismatch");
    chk_mpc_holds: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !(vector_out.valid && vector_out.save_sel == SAVE_MASKABLE) |->
        $stable(maskable_saved_pc_out))
        else $error("maskable save register moved without its event");
    chk_dpc_holds: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !(vector_out.valid && vector_out.save_sel == SAVE_DEBUG) |->
        $stable(debug_saved_pc_out))
        else $error("debug save register moved without its event");
    chk_trap_class: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        nmi_quiet_s ##0 illegal_opcode_exception_in |=>
        vector_out.save_sel == SAVE_NONMASKABLE && vector_out.code == CODE_ILLEGAL)
        else $error("illegal opcode saved to wrong register");
    chk_debug_class: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        nmi_quiet_s ##0 (debug_trap_in && !illegal_opcode_exception_in) |=>
        vector_out.save_sel == SAVE_DEBUG && vector_out.code == CODE_ILLEGAL)
        else $error("debug trap saved to wrong register");
    chk_follow_pc: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        maskable_turn_s ##0 (|live_req && !pipe_in.short_load && !pipe_in.divide
        && !pipe_in.frame_op) |=>
        vector_out.restored_pc == $past(pipe_in.following_instruction_address)
        && !vector_out.restart)
        else $error("maskable restored pc not the following address");
    chk_restart_pc: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        accept_in && watchdog_overflow_request_in && pipe_in.divide |=>
        vector_out.restored_pc == $past(pipe_in.current_pc) && vector_out.restart)
        else $error("divide not restarted");
    chk_frame_done: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        accept_in && ext_nmi_request_in && pipe_in.frame_op && pipe_in.sp_updated
        && !pipe_in.short_load && !pipe_in.divide |=>
        vector_out.restored_pc == $past(pipe_in.following_instruction_address)
        && !vector_out.restart)
        else $error("completed frame op restarted");
    chk_illegal_pc: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.code == CODE_ILLEGAL |->
        vector_out.restored_pc - ILLEGAL_OFFSET == $past(pipe_in.current_pc))
        else $error("illegal opcode restored pc wrong");
    chk_trap_resumes: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid && vector_out.code == CODE_ILLEGAL |-> !vector_out.restart)
        else $error("trap marked as restart");
    chk_handler_code: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        vector_out.valid |-> vector_out.handler == {16'h0000, vector_out.code})
        else $error("handler differs from code");
endmodule : interrupt_priority_vector_unit

// File: verilog/intc_vec_pkg.sv
// package for the upper maskable interrupt resolver: source table, codes and carriers
// assumes one clock domain; codes and handler addresses are fixed by the table below
package intc_vec_pkg;
    localparam int NUM_SRC      = 31;
    localparam int FIRST_LEVEL  = 22;
    localparam int PRIO_W       = 3;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h7;
    localparam logic [15:0] CODE_NONE     = 16'h0000;
    localparam logic [15:0] CODE_EXT_NMI  = 16'h0010;
    localparam logic [15:0] CODE_WDT      = 16'h0020;
    localparam logic [15:0] CODE_ILLEGAL  = 16'h0060;
    localparam logic [31:0] ILLEGAL_OFFSET = 32'h0000_0004;

    // exception code per source, index = default level - FIRST_LEVEL
    localparam logic [15:0] SRC_CODE [NUM_SRC] = '{
        16'h01e0, 16'h01f0, 16'h0200, 16'h0210, 16'h0220, 16'h0230, 16'h0240,
        16'h0250, 16'h0260, 16'h0270, 16'h0280, 16'h0290, 16'h02a0, 16'h02b0,
        16'h0300, 16'h0310, 16'h0320, 16'h0330, 16'h0340, 16'h0350, 16'h0360,
        16'h0370, 16'h0380, 16'h0390, 16'h03a0, 16'h03b0, 16'h03c0, 16'h0410,
        16'h0420, 16'h0430, 16'h0440};

    typedef enum logic [1:0] {SAVE_NONE, SAVE_MASKABLE, SAVE_NONMASKABLE, SAVE_DEBUG} save_sel_t;

    typedef struct packed {
        logic        short_load;
        logic        divide;
        logic        frame_op;
        logic        sp_updated;
        logic [31:0] current_pc;
        logic [31:0] following_instruction_address;
    } pipe_state_t;

    typedef struct packed {
        logic        valid;
        save_sel_t   save_sel;
        logic [15:0] code;
        logic [31:0] handler;
        logic [31:0] restored_pc;
        logic        restart;
    } vector_t;
endpackage : intc_vec_pkg

// File: verilog/prio_pick.sv
// finds the winning maskable request: lowest programmed level, then lowest default level
// assumes requests are already masked and levels are stable in the same cycle
`timescale 1ns/100ps
module prio_pick
    import intc_vec_pkg::*;
(
    // candidates
    input  wire logic [NUM_SRC-1:0]          req_in,
    input  wire logic [NUM_SRC*PRIO_W-1:0]   level_in,
    // result
    output logic                             found_out,
    output logic [4:0]                       index_out
);
    always_comb begin
        found_out = 1'b0;
        index_out = 5'h00;
        // scanning upward with a strict compare keeps the smaller index on ties
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req_in[i] && (!found_out ||
                level_in[i*PRIO_W +: PRIO_W] < level_in[index_out*PRIO_W +: PRIO_W])) begin
                found_out = 1'b1;
                index_out = 5'(i);
            end
        end
    end
endmodule : prio_pick

// File: testbench/core_model.sv
// core-side model: turns a one-cycle take strobe into the accept pulse
// assumes the bench changes take_in and pipe_cfg_in just after a clock edge
`timescale 1ns/100ps
module core_model
    import intc_vec_pkg::*;
(
    // clock
    input  wire logic                      clk_in,
    // bench control
    input  wire logic                      take_in,
    input  wire intc_vec_pkg::pipe_state_t pipe_cfg_in,
    // core side
    output logic                           accept_out,
    output intc_vec_pkg::pipe_state_t      pipe_out
);
    // pipe state moves with the pulse so it describes the boundary being taken
    always_ff @(posedge clk_in) begin
        accept_out <= take_in;
        pipe_out   <= pipe_cfg_in;
    end
endmodule : core_model

// File: testbench/interrupt_priority_vector_unit_tb.sv
// self-checking bench for the interrupt priority and vector unit
// assumes the core model delivers accept one cycle after the bench strobe
`timescale 1ns/100ps
module interrupt_priority_vector_unit_tb;
    import intc_vec_pkg::*;
    logic                      sys_clk_in, srst_in, nmi, wdt, ilg, dbg, ei, take, accept;
    logic [NUM_SRC-1:0]        req, msk;
    logic [NUM_SRC*PRIO_W-1:0] lvl;
    pipe_state_t               pcfg, pipe;
    vector_t                   vec;
    logic [31:0]               epc, fpc, dpc;
    int                        miscompares, tests_run;

    core_model i_core_model (.clk_in(sys_clk_in), .take_in(take), .pipe_cfg_in(pcfg),
        .accept_out(accept), .pipe_out(pipe));
    interrupt_priority_vector_unit i_interrupt_priority_vector_unit (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .mask_req_in(req), .mask_bit_in(msk),
        .prio_level_in(lvl), .ext_nmi_request_in(nmi), .watchdog_overflow_request_in(wdt),
        .illegal_opcode_exception_in(ilg), .debug_trap_in(dbg), .accept_in(accept),
        .maskable_enable_in(ei), .pipe_in(pipe), .vector_out(vec),
        .maskable_saved_pc_out(epc), .nonmaskable_saved_pc_out(fpc),
        .debug_saved_pc_out(dpc));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // expected code worked out from the level ranges, gaps after 35 and 48
    function automatic logic [15:0] code_of(input int i);
        if (i < 14) return 16'h01e0 + 16'(i * 16);
        if (i < 27) return 16'h0300 + 16'((i - 14) * 16);
        return 16'h0410 + 16'((i - 27) * 16);
    endfunction : code_of

    function automatic pipe_state_t pst(input logic [3:0] f);
        return '{f[3], f[2], f[1], f[0], 32'h0000_1000, 32'h0000_1004};
    endfunction : pst

    // strobe with ev = {pin nmi, watchdog, illegal, debug}, let the model raise accept,
    // then look one edge later while the one-cycle vector still stands
    task automatic fire(input logic [NUM_SRC-1:0] r, input logic [3:0] f, input logic [3:0] ev);
        @(posedge sys_clk_in);
        req                  <= r;
        pcfg                 <= pst(f);
        {nmi, wdt, ilg, dbg} <= ev;
        take                 <= 1'b1;
        @(posedge sys_clk_in);
        take <= 1'b0;
        @(posedge sys_clk_in);
        #1;
    endtask : fire

    task automatic t_table;
        for (int i = 0; i < NUM_SRC; i++) begin
            fire(31'(1) << i, 4'h0, 4'h0);
            chk("code", 32'(code_of(i)), 32'(vec.code));
            chk("handler", 32'(code_of(i)), vec.handler);
            chk("save_sel", 32'(SAVE_MASKABLE), 32'(vec.save_sel));
            chk("restored_pc", 32'h0000_1004, vec.restored_pc);
            chk("maskable_saved_pc", 32'h0000_1004, epc);
            @(posedge sys_clk_in);
            #1;
            chk("valid_drop", 32'h0, 32'(vec.valid));
        end
    endtask : t_table

    task automatic t_prio_mask;
        fire((31'(1) << 30) | (31'(1) << 3), 4'h0, 4'h0);
        chk("tie", 32'(code_of(3)), 32'(vec.code));
        @(posedge sys_clk_in);
        lvl[90 +: 3] <= 3'h0;
        fire((31'(1) << 30) | (31'(1) << 3), 4'h0, 4'h0);
        chk("level", 32'(code_of(30)), 32'(vec.code));
        @(posedge sys_clk_in);
        lvl <= {{(NUM_SRC * PRIO_W - 6){1'b1}}, 6'h00};
        fire(31'h3, 4'h0, 4'h0);
        chk("tie_at_top", 32'(code_of(0)), 32'(vec.code));
        @(posedge sys_clk_in);
        lvl <= '1;
        msk <= 31'h1;
        fire(31'h21, 4'h0, 4'h0);
        chk("masked", 32'(code_of(5)), 32'(vec.code));
        fire(31'h1, 4'h0, 4'h0);
        chk("all_masked", 32'h0, 32'(vec.valid));
        @(posedge sys_clk_in);
        msk <= '0;
        ei  <= 1'b0;
        fire(31'h1, 4'h0, 4'h0);
        chk("disabled", 32'h0, 32'(vec.valid));
        @(posedge sys_clk_in);
        ei <= 1'b1;
    endtask : t_prio_mask

    task automatic t_nmi_trap;
        fire(31'h1, 4'h0, 4'hc);
        chk("wdt_wins", 32'h20, 32'(vec.code));
        chk("nonmaskable_saved_pc", 32'h0000_1004, fpc);
        fire(31'h1, 4'h0, 4'h8);
        chk("nmi_pin", 32'h10, 32'(vec.code));
        chk("nmi_save_sel", 32'(SAVE_NONMASKABLE), 32'(vec.save_sel));
        fire(31'h1, 4'h4, 4'h4);
        chk("wdt_divide_pc", 32'h0000_1000, fpc);
        chk("wdt_divide_restart", 32'h1, 32'(vec.restart));
        fire(31'h0, 4'h0, 4'h2);
        chk("illegal_pc", 32'h0000_1000, vec.restored_pc - 32'h4);
        chk("illegal_code", 32'h60, 32'(vec.code));
        chk("illegal_saved_pc", 32'h0000_1004, fpc);
        fire(31'h0, 4'h3, 4'h8);
        chk("nmi_frame_pc", 32'h0000_1004, vec.restored_pc);
        chk("nmi_frame_restart", 32'h0, 32'(vec.restart));
        fire(31'h0, 4'h0, 4'h1);
        chk("debug_saved_pc", 32'h0000_1004, dpc);
        chk("debug_save_sel", 32'(SAVE_DEBUG), 32'(vec.save_sel));
    endtask : t_nmi_trap

    task automatic t_restart;
        logic [3:0] f [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
        for (int k = 0; k < 4; k++) begin
            fire(31'h1, f[k], 4'h0);
            chk("restart", {31'h0, k < 3}, 32'(vec.restart));
            chk("rpc", k < 3 ? 32'h0000_1000 : 32'h0000_1004, vec.restored_pc);
            chk("maskable_saved_pc", k < 3 ? 32'h0000_1000 : 32'h0000_1004, epc);
        end
    endtask : t_restart

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    initial begin
        {srst_in, ei} = 2'b11;
        {nmi, wdt, ilg, dbg, take} = '0;
        {req, msk} = '0;
        lvl = '1;
        pcfg = pst(4'h0);
        repeat (2) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        t_table();
        t_prio_mask();
        t_nmi_trap();
        t_restart();
        close_out();
    end
endmodule : interrupt_priority_vector_unit_tb
